// ---- dlt_lane_seq.sv ----
// Lane transition sequencer: transmit LP/HS ordering, receive settle windows, link capture.
//
// Summary of operation
// - Before a burst each lane walks LP-11, LP-01, LP-00 in that order.
// - Leaving a burst, the lane returns to the LP-11 stop state.
// - Data LP-00 prepare lasts 40 ns + 4 UI to 85 ns + 6 UI.
// - Receiver ignores data HS until 85 ns + 6 UI, responds by 145 ns + 10 UI.
// - Clock receiver ignores HS clock for a settable window of at most 300 ns.
// - Clock prepare plus clock zero lasts at least 300 ns.
// - Data prepare plus data zero lasts at least 145 ns + 10 UI.
// - Every driven low-power state lasts at least 50 ns.
// - HS clock runs a settable number of UI before data leaves LP.
// - HS clock keeps running a settable post time after data trail.
// - After the last clock bit the clock lane holds HS-0 for a trail time.
// - After the last data bit the data lane sends its inverse for a trail time.
// - All transition intervals are settable inputs, not fixed constants.
module dlt_lane_seq
    import dlt_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic tx_en,
    input wire logic tx_valid,
    input wire logic [BYTE_W-1:0] tx_data,
    output logic tx_ready,
    input wire logic [CNT_W-1:0] cfg_lpx,
    input wire logic [CNT_W-1:0] cfg_clk_prep,
    input wire logic [CNT_W-1:0] cfg_clk_zero,
    input wire logic [CNT_W-1:0] cfg_clk_pre_ui,
    input wire logic [CNT_W-1:0] cfg_clk_post,
    input wire logic [CNT_W-1:0] cfg_clk_trail,
    input wire logic [CNT_W-1:0] cfg_hs_prep,
    input wire logic [CNT_W-1:0] cfg_hs_zero,
    input wire logic [CNT_W-1:0] cfg_hs_trail,
    input wire logic [CNT_W-1:0] cfg_hs_settle,
    input wire logic [CNT_W-1:0] cfg_clk_settle,
    output logic [1:0] clk_lp_q,
    output logic clk_hs_en_q,
    output logic clk_run_q,
    output logic [1:0] dat_lp_q,
    output logic dat_hs_en_q,
    output logic [BYTE_W-1:0] dat_byte_q,
    output logic tx_busy_q,
    input wire logic [1:0] rx_clp,
    input wire logic [1:0] rx_dlp,
    input wire logic rx_hs_vld,
    input wire logic [BYTE_W-1:0] rx_hs_byte,
    output logic rx_hs_accept_q,
    output logic rx_clk_accept_q,
    output logic [BYTE_W-1:0] rx_data_q,
    output logic rx_vld_q
);
    // ==========================================================
    // State of the core domain
    typedef struct packed {
        dlt_tx_e st;
        logic [CNT_W-1:0] cnt;
        logic [1:0] clp;
        logic chs;
        logic crun;
        logic [1:0] dlp;
        logic dhs;
        logic [BYTE_W-1:0] dbyte;
        logic last;
        logic busy;
        logic [1:0] dsy1;
        logic [1:0] dsy2;
        logic [1:0] dprev;
        logic [1:0] csy1;
        logic [1:0] csy2;
        logic [1:0] cprev;
        logic don;
        logic [CNT_W-1:0] dset;
        logic dacc;
        logic con;
        logic [CNT_W-1:0] cset;
        logic cacc;
        logic tg1;
        logic tg2;
        logic tg3;
        logic [BYTE_W-1:0] rdata;
        logic rvld;
    } dlt_core_s;
    // State of the link domain
    typedef struct packed {
        logic acc1;
        logic acc2;
        logic tog;
        logic [BYTE_W-1:0] data;
    } dlt_link_s;
    dlt_core_s q;
    dlt_core_s d;
    dlt_link_s l;
    dlt_link_s ld;
    logic pop;
    dlt_fifo_if #(.W(BYTE_W)) fif ();
    dlt_fifo #(.W(BYTE_W), .D(DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .f(fif)
    );
    assign fif.wr_valid = tx_valid;
    assign fif.wr_data = tx_data;
    assign fif.rd_ready = pop;
    assign tx_ready = fif.wr_ready;
    // ==========================================================
    // Core next state
    always_comb
    begin
        logic [CNT_W-1:0] lpx;
        logic [CNT_W-1:0] cprep;
        logic [CNT_W-1:0] czero;
        logic [CNT_W-1:0] cpre;
        logic [CNT_W:0] pre_w;
        logic [CNT_W-1:0] hprep;
        logic [CNT_W-1:0] hzero;
        logic [CNT_W-1:0] hset;
        logic [CNT_W-1:0] cset;
        logic tdone;
        d = q;
        pop = 1'b0;
        // Settings are clamped so a bad value can never undershoot a minimum.
        lpx = dlt_clamp(cfg_lpx, LPX_CYC, '1);
        cprep = dlt_clamp(cfg_clk_prep, LPX_CYC, CLK_PREP_HI_CYC);
        czero = dlt_clamp(cfg_clk_zero, CLK_PZ_CYC - cprep, '1);
        pre_w = ({1'b0, cfg_clk_pre_ui} + (CNT_W + 1)'(BITS_PER_CLK - 1))
              / (CNT_W + 1)'(BITS_PER_CLK);
        cpre = dlt_clamp(pre_w[CNT_W-1:0], MIN_CYC, '1);
        hprep = dlt_clamp(cfg_hs_prep, HS_PREP_LO_CYC, HS_PREP_HI_CYC);
        hzero = dlt_clamp(cfg_hs_zero, HS_PZ_CYC - hprep, '1);
        hset = dlt_clamp(cfg_hs_settle, HS_SET_LO_CYC, HS_SET_HI_CYC);
        cset = dlt_clamp(cfg_clk_settle, LPX_CYC, CLK_SET_HI_CYC);
        tdone = q.cnt == '0;
        if (!tdone)
        begin
            d.cnt = q.cnt - 1'b1;
        end
        unique case (q.st)
            S_STOP:
            begin
                if (tdone && tx_en && fif.rd_valid)
                begin
                    d.st = S_CLP01;
                    d.cnt = lpx - MIN_CYC;
                end
            end
            S_CLP01:
            begin
                if (tdone)
                begin
                    d.st = S_CLP00;
                    d.cnt = cprep - MIN_CYC;
                end
            end
            S_CLP00:
            begin
                if (tdone)
                begin
                    d.st = S_CZERO;
                    d.cnt = czero - MIN_CYC;
                end
            end
            S_CZERO:
            begin
                if (tdone)
                begin
                    d.st = S_CPRE;
                    d.cnt = cpre - MIN_CYC;
                end
            end
            S_CPRE:
            begin
                if (tdone)
                begin
                    d.st = S_DLP01;
                    d.cnt = lpx - MIN_CYC;
                end
            end
            S_DLP01:
            begin
                if (tdone)
                begin
                    d.st = S_DLP00;
                    d.cnt = hprep - MIN_CYC;
                end
            end
            S_DLP00:
            begin
                if (tdone)
                begin
                    d.st = S_DZERO;
                    d.cnt = hzero - MIN_CYC;
                end
            end
            S_DZERO:
            begin
                if (tdone)
                begin
                    d.st = S_DSYNC;
                    d.last = SYNC_BYTE[BYTE_W-1];
                end
            end
            S_DSYNC, S_DDATA:
            begin
                // An empty FIFO ends the burst; an underrun splits the payload.
                if (fif.rd_valid)
                begin
                    d.st = S_DDATA;
                    pop = 1'b1;
                    d.last = fif.rd_data[BYTE_W-1];
                end
                else
                begin
                    d.st = S_DTRAIL;
                    d.cnt = dlt_clamp(cfg_hs_trail, MIN_CYC, '1) - MIN_CYC;
                end
            end
            S_DTRAIL:
            begin
                if (tdone)
                begin
                    d.st = S_CPOST;
                    d.cnt = dlt_clamp(cfg_clk_post, MIN_CYC, '1) - MIN_CYC;
                end
            end
            S_CPOST:
            begin
                if (tdone)
                begin
                    d.st = S_CTRAIL;
                    d.cnt = dlt_clamp(cfg_clk_trail, MIN_CYC, '1) - MIN_CYC;
                end
            end
            S_CTRAIL:
            begin
                if (tdone)
                begin
                    d.st = S_STOP;
                    d.cnt = lpx - MIN_CYC;
                end
            end
            default:
            begin
                d.st = S_STOP;
                d.cnt = lpx - MIN_CYC;
            end
        endcase
        // Lane drive follows the next state so every output is a flip-flop.
        d.clp = (d.st == S_CLP01) ? LP01 : ((d.st == S_STOP) ? LP11 : LP00);
        d.chs = !(d.st inside {S_STOP, S_CLP01, S_CLP00});
        d.crun = d.st inside {S_CPRE, S_DLP01, S_DLP00, S_DZERO, S_DSYNC, S_DDATA,
                              S_DTRAIL, S_CPOST};
        d.dhs = d.st inside {S_DZERO, S_DSYNC, S_DDATA, S_DTRAIL};
        d.dlp = (d.st == S_DLP01) ? LP01 : ((d.st == S_DLP00 || d.dhs) ? LP00 : LP11);
        unique case (d.st)
            S_DSYNC: d.dbyte = SYNC_BYTE;
            S_DDATA: d.dbyte = fif.rd_data;
            S_DTRAIL: d.dbyte = {BYTE_W{~d.last}};
            default: d.dbyte = '0;
        endcase
        d.busy = d.st != S_STOP;
        // ======================================================
        // Receive settle windows on synchronised line states
        d.dsy1 = rx_dlp;
        d.dsy2 = q.dsy1;
        d.dprev = q.dsy2;
        d.csy1 = rx_clp;
        d.csy2 = q.csy1;
        d.cprev = q.csy2;
        if (q.dsy2 == LP00 && q.dprev == LP01)
        begin
            d.don = 1'b1;
            d.dset = hset - CNT_W'(2);
            d.dacc = 1'b0;
        end
        else if (q.don)
        begin
            d.dset = q.dset - 1'b1;
            if (q.dset == '0)
            begin
                d.don = 1'b0;
                d.dacc = 1'b1;
            end
        end
        if (q.dsy2 == LP11)
        begin
            d.don = 1'b0;
            d.dacc = 1'b0;
        end
        if (q.csy2 == LP00 && q.cprev == LP01)
        begin
            d.con = 1'b1;
            d.cset = cset - CNT_W'(2);
            d.cacc = 1'b0;
        end
        else if (q.con)
        begin
            d.cset = q.cset - 1'b1;
            if (q.cset == '0)
            begin
                d.con = 1'b0;
                d.cacc = 1'b1;
            end
        end
        if (q.csy2 == LP11)
        begin
            d.con = 1'b0;
            d.cacc = 1'b0;
        end
        // ======================================================
        // Byte handover from the link domain by toggle
        d.tg1 = l.tog;
        d.tg2 = q.tg1;
        d.tg3 = q.tg2;
        d.rvld = q.tg2 != q.tg3;
        if (q.tg2 != q.tg3)
        begin
            d.rdata = l.data;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.clp <= LP11;
            q.dlp <= LP11;
            q.dsy1 <= LP11;
            q.dsy2 <= LP11;
            q.dprev <= LP11;
            q.csy1 <= LP11;
            q.csy2 <= LP11;
            q.cprev <= LP11;
        end
        else
        begin
            q <= d;
        end
    end
    // ==========================================================
    // Link domain: the byte register holds its value while the clock stops.
    always_comb
    begin
        ld = l;
        ld.acc1 = q.dacc;
        ld.acc2 = l.acc1;
        if (l.acc2 && rx_hs_vld)
        begin
            ld.data = rx_hs_byte;
            ld.tog = ~l.tog;
        end
    end
    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            l <= '0;
        end
        else
        begin
            l <= ld;
        end
    end
    assign clk_lp_q = q.clp;
    assign clk_hs_en_q = q.chs;
    assign clk_run_q = q.crun;
    assign dat_lp_q = q.dlp;
    assign dat_hs_en_q = q.dhs;
    assign dat_byte_q = q.dbyte;
    assign tx_busy_q = q.busy;
    assign rx_hs_accept_q = q.dacc;
    assign rx_clk_accept_q = q.cacc;
    assign rx_data_q = q.rdata;
    assign rx_vld_q = q.rvld;
    // ==========================================================
    // Checks
    logic [CNT_W-1:0] a_dcnt;
    logic [CNT_W-1:0] a_ccnt;
    logic [CNT_W-1:0] a_scnt;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a_dcnt <= '0;
            a_ccnt <= '0;
            a_scnt <= '0;
        end
        else
        begin
            a_dcnt <= (dat_lp_q == LP01) ? '0 : a_dcnt + CNT_W'(a_dcnt != '1);
            a_ccnt <= (clk_lp_q == LP01) ? '0 : a_ccnt + CNT_W'(a_ccnt != '1);
            a_scnt <= (q.dsy2 == LP01) ? '0 : a_scnt + CNT_W'(a_scnt != '1);
        end
    end
    default clocking a_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_lp01_hold;
        (dat_lp_q == LP01) [*5];
    endsequence
    sequence s_enter_prep;
        s_lp01_hold ##[0:260] (dat_lp_q == LP00);
    endsequence
    a_lp_order: assert property ($changed(dat_lp_q) && dat_lp_q == LP01 |->
        $past(dat_lp_q) == LP11 && clk_lp_q == LP00)
        else $error("Data lane left stop state out of order.");
    a_lpx_hold: assert property ($changed(dat_lp_q) && dat_lp_q == LP01 |->
        s_enter_prep)
        else $error("Data LP-01 shorter than the least low-power time.");
    a_prep_window: assert property ($rose(dat_hs_en_q) |->
        a_dcnt >= HS_PREP_LO_CYC && a_dcnt <= HS_PREP_HI_CYC)
        else $error("Data prepare time outside its window.");
    a_data_zero: assert property ($rose(q.st == S_DSYNC) |->
        a_dcnt >= HS_PZ_CYC && dat_byte_q == SYNC_BYTE)
        else $error("Data prepare plus zero too short before sync.");
    a_clk_zero: assert property ($rose(clk_run_q) |-> a_ccnt >= CLK_PZ_CYC)
        else $error("Clock prepare plus zero shorter than 300 ns.");
    a_hs_exit: assert property ($fell(dat_hs_en_q) |-> dat_lp_q == LP11)
        else $error("Data lane did not return to stop state.");
    a_clk_post: assert property ($fell(dat_hs_en_q) |->
        clk_run_q ##[1:260] !clk_run_q)
        else $error("Clock stopped before data trail ended.");
    a_clk_pre: assert property ($changed(dat_lp_q) && dat_lp_q == LP01 |->
        clk_run_q && $past(clk_run_q))
        else $error("Data left low power before the clock ran.");
    a_trail_flip: assert property ($rose(q.st == S_DTRAIL) |->
        dat_byte_q[0] != $past(dat_byte_q[BYTE_W-1]))
        else $error("Data trail does not invert the last bit.");
    a_clk_trail: assert property ($fell(clk_run_q) |->
        clk_hs_en_q ##[1:260] (clk_lp_q == LP11))
        else $error("Clock trail not held at HS-0 before stop.");
    a_rx_settle: assert property ($rose(rx_hs_accept_q) |->
        a_scnt >= HS_SET_LO_CYC && a_scnt <= HS_SET_HI_CYC)
        else $error("Data settle window outside its limits.");
endmodule : dlt_lane_seq

// ---- dlt_pkg.sv ----
// Timing constants, lane states and helpers for the lane transition sequencer.
package dlt_pkg;
    // ==========================================================
    // Rates and sizes
    localparam int CLK_PS = 10000;
    localparam int BITS_PER_CLK = 8;
    localparam int UI_PS = CLK_PS / BITS_PER_CLK;
    localparam int CNT_W = 8;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 32;
    // ==========================================================
    // Limits in picoseconds
    localparam int LPX_PS = 50000;
    localparam int HS_PREP_LO_PS = 40000 + 4 * UI_PS;
    localparam int HS_PREP_HI_PS = 85000 + 6 * UI_PS;
    localparam int HS_PZ_LO_PS = 145000 + 10 * UI_PS;
    localparam int HS_SET_LO_PS = 85000 + 6 * UI_PS;
    localparam int HS_SET_HI_PS = 145000 + 10 * UI_PS;
    localparam int CLK_PREP_HI_PS = 95000;
    localparam int CLK_PZ_LO_PS = 300000;
    localparam int CLK_SET_HI_PS = 300000;
    // ==========================================================
    // Cycle counts: least times round up, longest times round down.
    localparam logic [CNT_W-1:0] MIN_CYC = CNT_W'(1);
    localparam logic [CNT_W-1:0] LPX_CYC = CNT_W'((LPX_PS + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] HS_PREP_LO_CYC = CNT_W'((HS_PREP_LO_PS + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] HS_PREP_HI_CYC = CNT_W'(HS_PREP_HI_PS / CLK_PS);
    localparam logic [CNT_W-1:0] HS_PZ_CYC = CNT_W'((HS_PZ_LO_PS + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] HS_SET_LO_CYC = CNT_W'((HS_SET_LO_PS + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] HS_SET_HI_CYC = CNT_W'(HS_SET_HI_PS / CLK_PS);
    localparam logic [CNT_W-1:0] CLK_PREP_HI_CYC = CNT_W'(CLK_PREP_HI_PS / CLK_PS);
    localparam logic [CNT_W-1:0] CLK_PZ_CYC = CNT_W'((CLK_PZ_LO_PS + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] CLK_SET_HI_CYC = CNT_W'(CLK_SET_HI_PS / CLK_PS);
    // ==========================================================
    // Line states as {dp, dn} and burst framing
    localparam logic [1:0] LP11 = 2'h3;
    localparam logic [1:0] LP01 = 2'h1;
    localparam logic [1:0] LP00 = 2'h0;
    localparam logic [BYTE_W-1:0] SYNC_BYTE = 8'hB8;
    typedef enum logic [3:0] {
        S_STOP = 4'h0,
        S_CLP01 = 4'h1,
        S_CLP00 = 4'h3,
        S_CZERO = 4'h2,
        S_CPRE = 4'h6,
        S_DLP01 = 4'h7,
        S_DLP00 = 4'h5,
        S_DZERO = 4'h4,
        S_DSYNC = 4'hC,
        S_DDATA = 4'hD,
        S_DTRAIL = 4'hF,
        S_CPOST = 4'hE,
        S_CTRAIL = 4'hA
    } dlt_tx_e;
    // ==========================================================
    // Helpers
    function automatic logic [CNT_W-1:0] dlt_clamp(input logic [CNT_W-1:0] v,
                                                  input logic [CNT_W-1:0] lo,
                                                  input logic [CNT_W-1:0] hi);
        dlt_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : dlt_clamp
endpackage : dlt_pkg

// ---- dlt_fifo_if.sv ----
// Carrier between the lane sequencer and its payload FIFO.
interface dlt_fifo_if #(parameter int W = 8) ();
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    modport fifo (input wr_valid, input wr_data, output wr_ready,
                  output rd_valid, output rd_data, input rd_ready);
    modport user (output wr_valid, output wr_data, input wr_ready,
                  input rd_valid, input rd_data, output rd_ready);
endinterface : dlt_fifo_if

// ---- dlt_fifo.sv ----
// Payload FIFO of flip-flops with registered ready and valid flags.
module dlt_fifo
    import dlt_pkg::*;
#(
    parameter int W = BYTE_W,
    parameter int D = FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic rst_n,
    dlt_fifo_if.fifo f
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic wrdy;
        logic rvld;
    } dlt_fifo_s;
    dlt_fifo_s q;
    dlt_fifo_s d;
    logic push;
    logic pop;
    // ==========================================================
    // Next state
    always_comb
    begin
        d = q;
        push = f.wr_valid && q.wrdy;
        pop = f.rd_ready && q.rvld;
        if (push)
        begin
            d.mem[q.wp] = f.wr_data;
            d.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop)
        begin
            d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        // Flags are registered so the top sees them straight from flip-flops.
        d.wrdy = d.cnt != (AW + 1)'(D);
        d.rvld = d.cnt != '0;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.wrdy <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end
    assign f.wr_ready = q.wrdy;
    assign f.rd_valid = q.rvld;
    assign f.rd_data = q.mem[q.rp];
    a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
        q.cnt <= (AW + 1)'(D) && (q.rvld == (q.cnt != '0)))
        else $error("FIFO count out of range or valid flag stale.");
endmodule : dlt_fifo

// ---- dlt_peer.sv ----
// Far-side lane transmitter model that feeds the receive path.
module dlt_peer
    import dlt_pkg::*;
(
    output logic link_clk,
    output logic [1:0] rx_clp,
    output logic [1:0] rx_dlp,
    output logic rx_hs_vld,
    output logic [BYTE_W-1:0] rx_hs_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Idle lines
    // One link edge lands inside reset, since the link domain needs it.
    initial
    begin
        rx_clp = LP11;
        rx_dlp = LP11;
        rx_hs_vld = 1'b0;
        rx_hs_byte = 8'h00;
        link_clk = 1'b0;
        #20 link_clk = 1'b1;
        #40 link_clk = 1'b0;
    end
    // ==========================================================
    // One burst: three idle link cycles let the accept flag cross.
    task automatic frame(input logic [BYTE_W-1:0] b0, input logic [BYTE_W-1:0] b1);
        rx_clp = LP01;
        rx_dlp = LP01;
        #60;
        rx_clp = LP00;
        rx_dlp = LP00;
        #400;
        for (int i = 0; i < 5; i++)
        begin
            rx_hs_vld = (i >= 3);
            rx_hs_byte = (i == 3) ? b0 : ((i == 4) ? b1 : 8'(i));
            #40 link_clk = 1'b1;
            #40 link_clk = 1'b0;
        end
        rx_hs_vld = 1'b0;
        rx_hs_byte = ~rx_hs_byte;
        rx_clp = LP11;
        rx_dlp = LP11;
    endtask : frame
endmodule : dlt_peer

// ---- dlt_lane_seq_bench.sv ----
// Self-checking bench for the lane transition sequencer.
module dlt_lane_seq_bench
    import dlt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, tx_en = 0, tx_valid = 0, tx_ready, link_clk, rx_hs_vld;
    logic [7:0] tx_data = 8'h00, dat_byte_q, rx_hs_byte, rx_data_q;
    logic [CNT_W-1:0] cfg_lpx, cfg_clk_prep, cfg_clk_zero, cfg_clk_pre_ui, cfg_hs_prep;
    logic [CNT_W-1:0] cfg_hs_zero, cfg_hs_trail, cfg_clk_post, cfg_clk_trail;
    logic [CNT_W-1:0] cfg_hs_settle = 8'h0A, cfg_clk_settle = 8'h05;
    logic [1:0] clk_lp_q, dat_lp_q, rx_clp, rx_dlp;
    logic clk_hs_en_q, clk_run_q, dat_hs_en_q, tx_busy_q, rx_vld_q;
    logic rx_hs_accept_q, rx_clk_accept_q;
    int failures = 0, n_tests = 0;
    logic [7:0] rxq[$];
    always #5 clk = ~clk;
    dlt_lane_seq u_dut (.clk, .rst_n, .link_clk, .tx_en, .tx_valid, .tx_data, .tx_ready,
        .cfg_lpx, .cfg_clk_prep, .cfg_clk_zero, .cfg_clk_pre_ui, .cfg_clk_post,
        .cfg_clk_trail, .cfg_hs_prep, .cfg_hs_zero, .cfg_hs_trail, .cfg_hs_settle,
        .cfg_clk_settle, .clk_lp_q, .clk_hs_en_q, .clk_run_q, .dat_lp_q, .dat_hs_en_q,
        .dat_byte_q, .tx_busy_q, .rx_clp, .rx_dlp, .rx_hs_vld, .rx_hs_byte,
        .rx_hs_accept_q, .rx_clk_accept_q, .rx_data_q, .rx_vld_q);
    dlt_peer u_peer (.link_clk, .rx_clp, .rx_dlp, .rx_hs_vld, .rx_hs_byte);
    always @(negedge clk)
        if (rx_vld_q === 1'b1)
            rxq.push_back(rx_data_q);
    // ==========================================================
    // Reporting
    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // ==========================================================
    // Transmit lane words; the byte only counts while HS drives.
    function automatic logic [14:0] w(logic [1:0] cl, logic ch, logic cr, logic [1:0] dl,
                                      logic dh, logic [7:0] b);
        return {cl, ch, cr, dl, dh, dh ? b : 8'h00};
    endfunction : w
    task automatic fill(input logic [7:0] base, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk) tx_valid = 1'b1;
            tx_data = base + 8'(i);
        end
        @(negedge clk) tx_valid = 1'b0;
    endtask : fill
    // Settings order: lpx, clk prep, clk zero, pre, hs prep, hs zero, hs trail, post, clk trail.
    task automatic burst(input int c[9], input int e[9], input logic [7:0] base, input int n);
        logic [14:0] eq[$], gq[$], cur, v;
        int ec[$], gc[$], cnt, k;
        {cfg_lpx, cfg_clk_prep, cfg_clk_zero, cfg_clk_pre_ui, cfg_hs_prep} =
            {8'(c[0]), 8'(c[1]), 8'(c[2]), 8'(c[3]), 8'(c[4])};
        {cfg_hs_zero, cfg_hs_trail, cfg_clk_post, cfg_clk_trail} =
            {8'(c[5]), 8'(c[6]), 8'(c[7]), 8'(c[8])};
        eq = '{w(LP01, 0, 0, LP11, 0, 0), w(LP00, 0, 0, LP11, 0, 0), w(LP00, 1, 0, LP11, 0, 0),
               w(LP00, 1, 1, LP11, 0, 0), w(LP00, 1, 1, LP01, 0, 0), w(LP00, 1, 1, LP00, 0, 0),
               w(LP00, 1, 1, LP00, 1, 8'h00), w(LP00, 1, 1, LP00, 1, SYNC_BYTE)};
        ec = '{e[0], e[1], e[2], e[3], e[0], e[4], e[5], 1};
        for (int i = 0; i < n; i++)
        begin
            eq.push_back(w(LP00, 1, 1, LP00, 1, base + 8'(i)));
            ec.push_back(1);
        end
        eq.push_back(w(LP00, 1, 1, LP00, 1, {8{~eq[$][7]}}));
        eq.push_back(w(LP00, 1, 1, LP11, 0, 0));
        eq.push_back(w(LP00, 1, 0, LP11, 0, 0));
        ec = {ec, e[6], e[7], e[8]};
        @(negedge clk) tx_en = 1'b1;
        for (k = 0; k < 100 && clk_lp_q === LP11; k++)
            @(negedge clk);
        if (k == 100)
        begin
            failures++;
            final_report();
        end
        cmp(16'(tx_busy_q), 16'h0001);
        cur = w(clk_lp_q, clk_hs_en_q, clk_run_q, dat_lp_q, dat_hs_en_q, dat_byte_q);
        cnt = 0;
        for (k = 0; k < 400 && !(clk_lp_q === LP11 && dat_lp_q === LP11); k++)
        begin
            v = w(clk_lp_q, clk_hs_en_q, clk_run_q, dat_lp_q, dat_hs_en_q, dat_byte_q);
            if (v !== cur)
            begin
                gq.push_back(cur);
                gc.push_back(cnt);
                cur = v;
                cnt = 0;
            end
            cnt++;
            @(negedge clk);
        end
        tx_en = 1'b0;
        if (k == 400)
        begin
            failures++;
            final_report();
        end
        gq.push_back(cur);
        gc.push_back(cnt);
        cmp(16'(tx_busy_q), 16'h0000);
        cmp(16'(gq.size()), 16'(eq.size()));
        for (int i = 0; i < eq.size() && i < gq.size(); i++)
        begin
            cmp(16'(gq[i]), 16'(eq[i]));
            cmp(16'(gc[i]), 16'(ec[i]));
        end
    endtask : burst
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        fill(8'hC0, 2);
        burst('{6, 5, 25, 8, 6, 12, 3, 4, 2}, '{6, 5, 25, 1, 6, 12, 3, 4, 2}, 8'hC0, 2);
        $display("test nominal_burst done");
        fill(8'h40, 32);
        @(negedge clk) cmp(16'(tx_ready), 16'h0000);
        tx_valid = 1'b1;
        tx_data = 8'hAA;
        repeat (3) @(negedge clk);
        tx_valid = 1'b0;
        burst('{2, 20, 1, 9, 1, 1, 0, 0, 0}, '{5, 9, 21, 2, 5, 11, 1, 1, 1}, 8'h40, 32);
        $display("test full_fifo_clamped_burst done");
        fork
            u_peer.frame(8'h5A, 8'hA5);
            begin
                #100 cmp(16'({rx_clk_accept_q, rx_hs_accept_q}), 16'h0000);
                #60 cmp(16'({rx_clk_accept_q, rx_hs_accept_q}), 16'h0002);
                #200 cmp(16'({rx_clk_accept_q, rx_hs_accept_q}), 16'h0003);
            end
        join
        repeat (12) @(negedge clk);
        cmp(16'(rxq.size()), 16'h0002);
        cmp({rxq[0], rxq[1]}, 16'h5AA5);
        cmp(16'({rx_clk_accept_q, rx_hs_accept_q}), 16'h0000);
        $display("test receive_settle done");
        final_report();
    end
endmodule : dlt_lane_seq_bench
